// ===== nipc_pkg.sv
// Shared constants and types for the nested interrupt priority controller.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
package nipc_pkg;

  localparam int NSRC = 8;
  localparam int SRC_W = 3;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_PSW = 8'h0C;
  localparam logic [7:0] OFF_ISTAT = 8'h10;
  localparam logic [7:0] OFF_IMASK = 8'h14;

  // Reset values
  localparam logic [7:0] PSW_RST = 8'h06;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [15:0] PRIO_RST = 16'hFFFF;
  localparam logic [7:0] REQ_RST = 8'h00;
  localparam logic [1:0] EV_RST = 2'h0;

  // Status word fields
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_HI = 2;
  localparam int PSW_ISP_LO = 1;
  localparam logic [1:0] LEVEL_ZERO = 2'h0;

  // Event bits of the interrupt status and mask registers
  localparam int EV_ACK = 0;
  localparam int EV_BRK = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    KIND_PLAIN = 4'h0,
    KIND_EI = 4'h1,
    KIND_DI = 4'h2,
    KIND_PSW_WR = 4'h3,
    KIND_IRQ_RETURN_INSTRUCTION = 4'h4,
    KIND_BREAK_RETURN_INSTRUCTION = 4'h5,
    KIND_POP_PSW = 4'h6,
    KIND_SKIP = 4'h7,
    KIND_BRK = 4'h8
  } nipc_kind_t;

  // One completed instruction from the pipeline
  typedef struct packed {
    logic done;
    nipc_kind_t kind;
    logic [7:0] psw_data;
  } nipc_cpu_t;

  // Acknowledge handed back to the pipeline
  typedef struct packed {
    logic valid;
    logic software_break_instruction;
    logic [SRC_W-1:0] src;
    logic [1:0] level;
    logic [7:0] saved_psw;
  } nipc_ack_t;

endpackage

// ===== nipc_top.sv
// Nested interrupt priority controller: request flags, arbitration, status word.
// Assumes CPU_IN comes from logic on SYS_CLK; IRQ_REQ pins are asynchronous.
//
// What this block does
// - Any acknowledge clears the global enable flag
// - No nesting unless the enable flag is set
// - Strictly higher priority request nests when enabled
// - Equal or lower priority nests only as level 0 over level 0, during break service, or over a level 0 acknowledged at service level 1 to 3
// - Level 0 may nest over level 0
// - Refused requests stay pending until eligible
// - One main instruction runs after a return
// - Service level field encodes level in service
// - Two priority bits select level 0 to 3
// - Break always accepted; break service accepts all levels
// - Listed instructions defer acknowledge one instruction
// - Writes to request, mask, priority defer acknowledge
// - Lowest level number wins, ties by lowest index
// - Level 1 to 3 acknowledge loads service level with priority minus one; level 0 and break leave it
// - Status word saved on acknowledge, restored on return
// - Reset puts status word at 06H
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module nipc_top (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [nipc_pkg::NSRC-1:0] IRQ_REQ,
  input wire nipc_pkg::nipc_cpu_t CPU_IN,
  output nipc_pkg::nipc_ack_t ACK_OUT,
  output logic [7:0] PSW_OUT,
  output logic IRQ_OUT,
  input wire logic [nipc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [nipc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import nipc_pkg::*;

  logic [NSRC-1:0] sync1_r, sync2_r, prev_r, rise;
  logic [NSRC-1:0] req_r, req_nxt, mask_r, eligible;
  logic [15:0] prio_r;
  logic [7:0] psw_r;
  logic brk_svc_r, hold_wr_r;
  logic [1:0] istat_r, istat_nxt, imask_r;
  logic [1:0] isp;
  logic ie;
  logic aw_have_r, w_have_r, do_wr;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_hs, w_hs, ar_hs;
  logic wr_req, wr_mask, wr_prio, wr_istat, wr_imask, wr_ctl, wr_known;
  logic found;
  logic [SRC_W-1:0] best_idx;
  logic [1:0] best_lvl;
  logic kind_defers, take_irq, take_brk;
  logic [31:0] req_m, mask_m, prio_m;
  nipc_ack_t ack_r;

  assign isp = psw_r[PSW_ISP_HI:PSW_ISP_LO];
  assign ie = psw_r[PSW_IE_BIT];

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pin synchroniser and rising-edge detect
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sync1_r <= REQ_RST;
      sync2_r <= REQ_RST;
      prev_r <= REQ_RST;
    end else begin
      sync1_r <= IRQ_REQ;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  assign rise = sync2_r & ~prev_r;

  // AXI write path
  assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
  assign do_wr = aw_have_r & w_have_r & ~S_AXI_BVALID;
  assign wr_req = do_wr && awaddr_r == OFF_REQ;
  assign wr_mask = do_wr && awaddr_r == OFF_MASK;
  assign wr_prio = do_wr && awaddr_r == OFF_PRIO;
  assign wr_istat = do_wr && awaddr_r == OFF_ISTAT;
  assign wr_imask = do_wr && awaddr_r == OFF_IMASK;
  assign wr_ctl = wr_req | wr_mask | wr_prio;
  assign wr_known = wr_ctl | wr_istat | wr_imask || awaddr_r == OFF_PSW;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? RESP_OKAY : RESP_DECERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      S_AXI_AWREADY <= ~(aw_have_r | aw_hs) & ~do_wr & ~(S_AXI_BVALID & ~S_AXI_BREADY);
      S_AXI_WREADY <= ~(w_have_r | w_hs) & ~do_wr & ~(S_AXI_BVALID & ~S_AXI_BREADY);
    end
  end

  // AXI read path
  assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      if (ar_hs) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= RESP_OKAY;
        case (S_AXI_ARADDR)
          OFF_REQ: S_AXI_RDATA <= {24'h0, req_r};
          OFF_MASK: S_AXI_RDATA <= {24'h0, mask_r};
          OFF_PRIO: S_AXI_RDATA <= {16'h0, prio_r};
          OFF_PSW: S_AXI_RDATA <= {24'h0, psw_r};
          OFF_ISTAT: S_AXI_RDATA <= {30'h0, istat_r};
          OFF_IMASK: S_AXI_RDATA <= {30'h0, imask_r};
          default: begin
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= RESP_DECERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
      S_AXI_ARREADY <= ~ar_hs & ~(S_AXI_RVALID & ~S_AXI_RREADY);
    end
  end

  // Merged register images, sliced to width where they are used
  assign req_m = merge({24'h0, req_r}, wdata_r, wstrb_r);
  assign mask_m = merge({24'h0, mask_r}, wdata_r, wstrb_r);
  assign prio_m = merge({16'h0, prio_r}, wdata_r, wstrb_r);

  always_comb begin
    req_nxt = req_r;
    if (wr_req) begin
      req_nxt = req_m[NSRC-1:0];
    end
    if (take_irq) begin
      req_nxt[best_idx] = 1'b0;
    end
    req_nxt = req_nxt | rise;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      req_r <= REQ_RST;
      mask_r <= MASK_RST;
      prio_r <= PRIO_RST;
    end else begin
      req_r <= req_nxt;
      if (wr_mask) begin
        mask_r <= mask_m[NSRC-1:0];
      end
      if (wr_prio) begin
        prio_r <= prio_m[15:0];
      end
    end
  end

  assign eligible = req_r & ~mask_r;
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_lvl = '1;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!found || prio_r[2*i +: 2] <= best_lvl)) begin
        found = 1'b1;
        best_idx = SRC_W'(i);
        best_lvl = prio_r[2*i +: 2];
      end
    end
  end

  always_comb begin
    case (CPU_IN.kind)
      KIND_EI, KIND_DI, KIND_PSW_WR, KIND_IRQ_RETURN_INSTRUCTION, KIND_BREAK_RETURN_INSTRUCTION, KIND_POP_PSW, KIND_SKIP: begin
        kind_defers = 1'b1;
      end
      default: kind_defers = 1'b0;
    endcase
  end

  // control writes hold off one boundary
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      hold_wr_r <= 1'b0;
    end else begin
      hold_wr_r <= wr_ctl | (hold_wr_r & ~CPU_IN.done);
    end
  end

  assign take_brk = CPU_IN.done && CPU_IN.kind == KIND_BRK;
  // level and enable check at boundary
  assign take_irq = CPU_IN.done & ~kind_defers & ~take_brk & ~hold_wr_r & ~wr_ctl & found &
                    ie & (brk_svc_r | best_lvl <= isp);

  // Status word updates
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      psw_r <= PSW_RST;
    end else if (take_irq || take_brk) begin
      psw_r[PSW_IE_BIT] <= 1'b0;
      if (take_irq && best_lvl != LEVEL_ZERO) begin
        psw_r[PSW_ISP_HI:PSW_ISP_LO] <= best_lvl - 2'h1;
      end
    end else if (CPU_IN.done) begin
      case (CPU_IN.kind)
        KIND_EI: psw_r[PSW_IE_BIT] <= 1'b1;
        KIND_DI: psw_r[PSW_IE_BIT] <= 1'b0;
        KIND_PSW_WR, KIND_IRQ_RETURN_INSTRUCTION, KIND_BREAK_RETURN_INSTRUCTION, KIND_POP_PSW: psw_r <= CPU_IN.psw_data;
        default: psw_r <= psw_r;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      brk_svc_r <= 1'b0;
    end else if (take_brk) begin
      brk_svc_r <= 1'b1;
    end else if (CPU_IN.done && CPU_IN.kind == KIND_BREAK_RETURN_INSTRUCTION) begin
      brk_svc_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ack_r <= '0;
    end else begin
      ack_r.valid <= take_irq | take_brk;
      ack_r.software_break_instruction <= take_brk;
      ack_r.src <= take_irq ? best_idx : '0;
      ack_r.level <= take_irq ? best_lvl : '0;
      ack_r.saved_psw <= psw_r;
    end
  end

  // Event status, set wins over clear
  always_comb begin
    istat_nxt = istat_r;
    if (wr_istat) begin
      istat_nxt = istat_nxt & ~wdata_r[1:0];
    end
    istat_nxt[EV_ACK] = istat_nxt[EV_ACK] | take_irq;
    istat_nxt[EV_BRK] = istat_nxt[EV_BRK] | take_brk;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      istat_r <= EV_RST;
      imask_r <= EV_RST;
      IRQ_OUT <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      if (wr_imask && wstrb_r[0]) begin
        imask_r <= wdata_r[1:0];
      end
      IRQ_OUT <= |(istat_r & imask_r);
    end
  end

  assign ACK_OUT = ack_r;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PSW_OUT <= PSW_RST;
    end else begin
      PSW_OUT <= psw_r;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_brk_done;
    CPU_IN.done && CPU_IN.kind == KIND_BRK;
  endsequence
  sequence s_irq_return_instruction_done;
    CPU_IN.done && CPU_IN.kind == KIND_IRQ_RETURN_INSTRUCTION;
  endsequence

  property p_ie_clear;
    take_irq |=> !psw_r[PSW_IE_BIT] && ack_r.valid;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable flag not cleared on ack");

  property p_ack_needs_ie;
    ack_r.valid && !ack_r.software_break_instruction |-> !$past(ack_r.valid) && ack_r.saved_psw[PSW_IE_BIT];
  endproperty
  a_ack_needs_ie: assert property (p_ack_needs_ie) else $error("ack taken with enable off");

  property p_level_ok;
    take_irq && !brk_svc_r |-> best_lvl <= isp;
  endproperty
  a_level_ok: assert property (p_level_ok) else $error("nested ack of too low a level");

  property p_higher_taken;
    CPU_IN.done && !kind_defers && !take_brk && !hold_wr_r && !wr_ctl && ie && found &&
      best_lvl < isp |-> take_irq;
  endproperty
  a_higher_taken: assert property (p_higher_taken) else $error("higher level not nested");

  property p_level0_nest;
    ie && isp == LEVEL_ZERO && found && best_lvl == LEVEL_ZERO && CPU_IN.done &&
      !kind_defers && !take_brk && !hold_wr_r && !wr_ctl |=> ack_r.valid;
  endproperty
  a_level0_nest: assert property (p_level0_nest) else $error("level 0 not nested");

  property p_pending_kept;
    (|(req_r & ~req_nxt)) |-> take_irq || wr_req;
  endproperty
  a_pending_kept: assert property (p_pending_kept) else $error("pending request dropped");

  property p_defer_kind;
    CPU_IN.done && kind_defers |=> !ack_r.valid;
  endproperty
  a_defer_kind: assert property (p_defer_kind) else $error("ack after deferring instruction");

  property p_irq_return_instruction_gap;
    s_irq_return_instruction_done |=> !ack_r.valid ##0 psw_r == $past(CPU_IN.psw_data);
  endproperty
  a_irq_return_instruction_gap: assert property (p_irq_return_instruction_gap) else $error("return not followed correctly");

  property p_defer_write;
    wr_ctl ##1 CPU_IN.done |-> !take_irq;
  endproperty
  a_defer_write: assert property (p_defer_write) else $error("ack right after control write");

  property p_brk;
    s_brk_done |=> ack_r.valid && ack_r.software_break_instruction && brk_svc_r && !psw_r[PSW_IE_BIT];
  endproperty
  a_brk: assert property (p_brk) else $error("break not acknowledged");

  property p_isp_load;
    ack_r.valid && !ack_r.software_break_instruction && ack_r.level != LEVEL_ZERO |-> isp == ack_r.level - 2'h1;
  endproperty
  a_isp_load: assert property (p_isp_load) else $error("service level not loaded");

  property p_reset_psw;
    $past(SRST) |-> psw_r == PSW_RST || !$past(SRST, 2);
  endproperty
  a_reset_psw: assert property (p_reset_psw) else $error("status word reset value wrong");

endmodule

// ===== nipc_cpu_model.sv
// Pipeline model: turns one issue request into one instruction-complete pulse.
// Assumes the bench drives issue, kind and data just after a rising edge of clk.
`timescale 1ns/1ps
module nipc_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue,
  input wire nipc_pkg::nipc_kind_t kind,
  input wire logic [7:0] data,
  output nipc_pkg::nipc_cpu_t cpu
);
  import nipc_pkg::*;

  // Payload is scrambled outside the done cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu <= '0;
    end else begin
      cpu.done <= issue;
      cpu.kind <= issue ? kind : nipc_kind_t'(~kind);
      cpu.psw_data <= issue ? data : ~data;
    end
  end
endmodule

// ===== test_nested_interrupt_priority_control.sv
// Self-checking bench for the nested interrupt priority controller.
// Assumes nipc_pkg, nipc_top and nipc_cpu_model are compiled first.
`timescale 1ns/1ps
module test_nested_interrupt_priority_control;
  import nipc_pkg::*;
  logic clk = 0, srst = 1, issue = 0;
  logic [7:0] irq = '0, psw_d = '0, awaddr = '0, araddr = '0, program_status_word;
  nipc_kind_t kind = KIND_PLAIN;
  nipc_cpu_t cpu;
  nipc_ack_t ack;
  logic irq_out, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [13:0] exp_q[$];
  int n_fail = 0, checks_done = 0;

  initial forever #20 clk = ~clk;

  nipc_cpu_model nipc_cpu_model_inst (.clk(clk), .rst(srst), .issue(issue), .kind(kind),
    .data(psw_d), .cpu(cpu));

  nipc_top nipc_top_inst (.SYS_CLK(clk), .SRST(srst), .IRQ_REQ(irq), .CPU_IN(cpu),
    .ACK_OUT(ack), .PSW_OUT(program_status_word), .IRQ_OUT(irq_out), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo(input int n);
    if (n > 60) begin
      n_fail++;
      $display("unexpected handshake: expected answer seen timeout");
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      tmo(n);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      tmo(n);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask

  task automatic instr(input nipc_kind_t k, input logic [7:0] d);
    @(posedge clk);
    issue <= 1'b1;
    kind <= k;
    psw_d <= d;
    @(posedge clk);
    issue <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic raise(input int i);
    @(posedge clk);
    irq[i] <= 1'b1;
    repeat (4) @(posedge clk);
    irq[i] <= 1'b0;
  endtask

  task automatic exp_ack(input logic b, input logic [2:0] s, input logic [1:0] l,
                         input logic [7:0] p);
    exp_q.push_back({b, s, l, p});
  endtask

  // Every acknowledge must match the oldest expectation
  always @(posedge clk) begin
    if (ack.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        checks_done++;
        $display("unexpected ack: expected none seen %h", ack);
      end else
        chk("ack", exp_q.pop_front(), {ack.software_break_instruction, ack.src, ack.level, ack.saved_psw});
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'h07E8AF4F));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFF_PSW, 32'h06, RESP_OKAY);
    rd(OFF_MASK, 32'hFF, RESP_OKAY);
    rd(OFF_PRIO, 32'hFFFF, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_DECERR);
    wr(8'h1C, 32'h0, RESP_DECERR);
    $display("test reset done");
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    wr(OFF_PRIO, 32'hFF84, RESP_OKAY);
    raise(3);
    instr(KIND_EI, 8'h00);
    exp_ack(1'b0, 3'd3, 2'h2, 8'h86);
    instr(KIND_PLAIN, 8'h00);
    chk("psw", 32'h02, program_status_word);
    raise(5);
    instr(KIND_EI, 8'h00);
    instr(KIND_PLAIN, 8'h00);
    raise(1);
    exp_ack(1'b0, 3'd1, 2'h1, 8'h82);
    instr(KIND_PLAIN, 8'h00);
    chk("psw", 32'h00, program_status_word);
    $display("test nesting done");
    raise(0);
    instr(KIND_PLAIN, 8'h00);
    instr(KIND_EI, 8'h00);
    exp_ack(1'b0, 3'd0, 2'h0, 8'h80);
    instr(KIND_PLAIN, 8'h00);
    chk("psw", 32'h00, program_status_word);
    raise(2);
    instr(KIND_EI, 8'h00);
    exp_ack(1'b0, 3'd2, 2'h0, 8'h80);
    instr(KIND_PLAIN, 8'h00);
    instr(KIND_IRQ_RETURN_INSTRUCTION, 8'h86);
    chk("psw", 32'h86, program_status_word);
    exp_ack(1'b0, 3'd5, 2'h3, 8'h86);
    instr(KIND_PLAIN, 8'h00);
    chk("psw", 32'h04, program_status_word);
    $display("test level zero and return done");
    exp_ack(1'b1, 3'd0, 2'h0, 8'h04);
    instr(KIND_BRK, 8'h00);
    raise(4);
    instr(KIND_EI, 8'h00);
    exp_ack(1'b0, 3'd4, 2'h3, 8'h84);
    instr(KIND_PLAIN, 8'h00);
    instr(KIND_BREAK_RETURN_INSTRUCTION, 8'h86);
    raise(6);
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    instr(KIND_PLAIN, 8'h00);
    exp_ack(1'b0, 3'd6, 2'h3, 8'h86);
    instr(KIND_PLAIN, 8'h00);
    $display("test break and write deferral done");
    for (int i = 1; i < 8; i++) begin
      d = 8'h86 | (8'($urandom()) & 8'h79);
      raise(7);
      instr(KIND_POP_PSW, d);
      instr(nipc_kind_t'(i), d);
      instr(KIND_EI, d);
      exp_ack(1'b0, 3'd7, 2'h3, d);
      instr(KIND_PLAIN, 8'h00);
    end
    $display("test instruction deferral done");
    rd(OFF_ISTAT, 32'h3, RESP_OKAY);
    chk("irq_out", 32'h0, irq_out);
    wr(OFF_IMASK, 32'h1, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq_out", 32'h1, irq_out);
    wr(OFF_IMASK, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq_out", 32'h0, irq_out);
    wr(OFF_ISTAT, 32'h1, RESP_OKAY);
    wr(OFF_IMASK, 32'h3, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq_out", 32'h1, irq_out);
    wr(OFF_ISTAT, 32'h2, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq_out", 32'h0, irq_out);
    rd(OFF_ISTAT, 32'h0, RESP_OKAY);
    $display("test event interrupt done");
    repeat (5) @(posedge clk);
    chk("pending acks", 32'h0, exp_q.size());
    conclude();
  end
endmodule
